// file: hw/fhsc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: Status A/B readable in enhanced mode; basic mode leaves bus undriven.
// RQ2: Enhanced status A bit layout from direction through interrupt pending.
// RQ3: Alternate status A layout with inverted direction, head; given reset values.
// RQ4: Alternate latched step sets on step active; input-status read or reset clears.
// RQ5: Status A bit 7 follows interrupt output level, resets to zero.
// RQ6: Enhanced status B bits 7,6 read one; bit 2 shows write gate.
// RQ7: Enhanced status B bits 1:0 mirror motors 1:0; hardware reset only.
// RQ8: Enhanced status B bits 3,4 toggle on inactive read/write data edges.
// RQ9: Enhanced status B bit 5 follows unit select bit 0 field.
// RQ10: Alternate status B shows inverted selects, data latches, second unit.
// RQ11: Write gate latch sets on rising write gate; input-status read clears.
// RQ12: Read/write data latches set on inactive edges; write data ungated.
// RQ13: Drive output control writable anytime, zero on hardware reset only.
// RQ14: Bits 1:0 decode to exactly one of four unit selects.
// RQ15: Bit 2 low holds controller reset; other settings untouched.
// RQ16: Two consecutive writes clearing then setting bit 2 give full reset.
// RQ17: Basic/alternate modes gate DMA and interrupt with bit 3.
// RQ18: Enhanced mode always enables DMA and interrupt pins, even in reset.
// RQ19: Bits 7:4 drive motor outputs 3:0 active when set.
// RQ20: Host writes 1c, 2d, 4e, 8f to activate drives 0 to 3.
// RQ21: Only listed offsets decode; 4 and 7 split read/write; 6 reserved.
// RQ22: Offset 5 data port, 3 tape select, 2 drive output control.
// RQ23: Host mode is a static configuration input.
module fhsc_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Static configuration
  input wire fhsc_pkg::fhsc_mode_t host_mode, // RQ23
  // Host I/O bus
  input wire logic [2:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  input wire logic io_wr,
  output logic [7:0] io_rdata_q,
  output logic [7:0] io_rdata_oe_q,
  // Registers held elsewhere in the controller
  input wire logic [7:0] ext_rd_data,
  output logic ext_rd_q,
  output logic ext_wr_q,
  output logic [2:0] ext_addr_q,
  output logic [7:0] ext_wdata_q,
  // Drive interface
  input wire fhsc_pkg::fhsc_drive_t drive_in,
  output logic [3:0] unit_select_q,
  output logic [3:0] motor_on_q,
  // Controller core and DMA pins
  input wire fhsc_pkg::fhsc_dma_t core_in,
  output logic soft_reset_n_q,
  output logic dma_gate_enable_q,
  output logic drq_out_q,
  output logic drq_oe_q,
  output logic controller_irq_out_q,
  output logic controller_irq_oe_q,
  output logic dack_n_gated_q,
  output logic tc_gated_q
);

  logic [7:0] doc_q;
  logic [7:0] doc_d;
  logic [1:0] tape_q;
  logic [3:0] srst_cnt_q;
  logic srst_active;
  logic pins_enable;
  logic wr_doc;
  logic rd_input_status;
  logic step_prev_q;
  logic wr_gate_prev_q;
  logic rdata_prev_q;
  logic wdata_prev_q;
  logic step_rise;
  logic wr_gate_rise;
  logic rdata_fall;
  logic wdata_fall;
  logic step_latch_q;
  logic wr_gate_latch_q;
  logic rdata_latch_q;
  logic wdata_latch_q;
  logic rdata_toggle_q;
  logic wdata_toggle_q;
  logic irq_level_q;
  logic [7:0] status_a_enh;
  logic [7:0] status_a_alt;
  logic [7:0] status_b_enh;
  logic [7:0] status_b_alt;
  logic [7:0] rd_val;
  logic [7:0] rd_oe;

  localparam logic [3:0] SRST_LOAD = 4'(fhsc_pkg::SRST_MIN_CYC);

  assign wr_doc = io_wr && (io_addr == fhsc_pkg::OFS_DRIVE_OUT);
  assign rd_input_status = io_rd && (io_addr == fhsc_pkg::OFS_INPUT_CFG);

  // Drive output control register
  always_comb begin
    doc_d = doc_q;
    if (wr_doc) begin
      doc_d = io_wdata; // RQ13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      doc_q <= fhsc_pkg::DOC_RESET; // RQ13
    end else begin
      doc_q <= doc_d; // RQ13
    end
  end

  // Tape select keeps only the two select bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tape_q <= fhsc_pkg::TAPE_RESET;
    end else if (io_wr && (io_addr == fhsc_pkg::OFS_TAPE_SEL)) begin
      tape_q <= io_wdata[1:0]; // RQ22
    end
  end

  // Reset stretch covers back-to-back clear/set writes shorter than the core needs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      srst_cnt_q <= 4'h0;
    end else if (wr_doc && !io_wdata[fhsc_pkg::DOC_RESET_N]) begin
      srst_cnt_q <= SRST_LOAD; // RQ16
    end else if (srst_cnt_q != 4'h0) begin
      srst_cnt_q <= srst_cnt_q - 4'h1; // RQ16
    end
  end

  assign srst_active = !doc_q[fhsc_pkg::DOC_RESET_N] || (srst_cnt_q != 4'h0);

  // Core reset; hardware reset also holds the core
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      soft_reset_n_q <= 1'b0;
    end else begin
      soft_reset_n_q <= !(!doc_d[fhsc_pkg::DOC_RESET_N] || srst_active); // RQ15
    end
  end

  // Drive selects and motors follow the register one cycle later
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_select_q <= fhsc_pkg::SEL_RESET;
      motor_on_q <= 4'h0;
    end else begin
      unit_select_q <= 4'h1 << doc_q[fhsc_pkg::DOC_SEL_HI:fhsc_pkg::DOC_SEL_LO]; // RQ14
      motor_on_q <= doc_q[fhsc_pkg::DOC_MOTOR_HI:fhsc_pkg::DOC_MOTOR_LO]; // RQ19
    end
  end

  // DMA and interrupt pin gating
  assign pins_enable = (host_mode == fhsc_pkg::MODE_ENHANCED) || doc_q[fhsc_pkg::DOC_DMA_EN];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dma_gate_enable_q <= 1'b0;
      drq_out_q <= 1'b0;
      // Enhanced mode keeps the pins enabled through a hardware reset
      drq_oe_q <= (host_mode == fhsc_pkg::MODE_ENHANCED); // RQ18
      controller_irq_out_q <= 1'b0;
      controller_irq_oe_q <= (host_mode == fhsc_pkg::MODE_ENHANCED); // RQ18
      dack_n_gated_q <= 1'b1;
      tc_gated_q <= 1'b0;
    end else begin
      dma_gate_enable_q <= doc_q[fhsc_pkg::DOC_DMA_EN];
      // Enhanced mode ignores the bit and keeps pins live through soft reset
      drq_out_q <= core_in.drq; // RQ17 RQ18
      drq_oe_q <= pins_enable; // RQ17 RQ18
      controller_irq_out_q <= core_in.irq; // RQ17 RQ18
      controller_irq_oe_q <= pins_enable; // RQ17 RQ18
      dack_n_gated_q <= pins_enable ? core_in.dack_n : 1'b1; // RQ17
      tc_gated_q <= pins_enable && core_in.tc; // RQ17
    end
  end

  // Interrupt level as seen on the output pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_level_q <= 1'b0; // RQ5
    end else begin
      irq_level_q <= core_in.irq; // RQ5
    end
  end

  // Edge detection on drive signals
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_prev_q <= 1'b0;
      wr_gate_prev_q <= 1'b0;
      rdata_prev_q <= 1'b0;
      wdata_prev_q <= 1'b0;
    end else begin
      step_prev_q <= drive_in.step_out;
      wr_gate_prev_q <= drive_in.write_gate;
      rdata_prev_q <= drive_in.read_data;
      wdata_prev_q <= drive_in.write_data;
    end
  end

  assign step_rise = drive_in.step_out && !step_prev_q;
  assign wr_gate_rise = drive_in.write_gate && !wr_gate_prev_q;
  assign rdata_fall = !drive_in.read_data && rdata_prev_q;
  assign wdata_fall = !drive_in.write_data && wdata_prev_q;

  // Step latch; a new step wins over a clearing read
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      step_latch_q <= 1'b0; // RQ4
    end else if (step_rise) begin
      step_latch_q <= 1'b1; // RQ4
    end else if (rd_input_status || srst_active) begin
      step_latch_q <= 1'b0; // RQ4
    end
  end

  // Write gate latch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_gate_latch_q <= 1'b0; // RQ11
    end else if (wr_gate_rise) begin
      wr_gate_latch_q <= 1'b1; // RQ11
    end else if (rd_input_status) begin
      wr_gate_latch_q <= 1'b0; // RQ11
    end
  end

  // Data latches; write data deliberately not qualified by write gate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_latch_q <= 1'b0;
      wdata_latch_q <= 1'b0;
    end else begin
      if (rdata_fall) begin
        rdata_latch_q <= 1'b1; // RQ12
      end else if (rd_input_status) begin
        rdata_latch_q <= 1'b0; // RQ12
      end
      if (wdata_fall) begin
        wdata_latch_q <= 1'b1; // RQ12
      end else if (rd_input_status) begin
        wdata_latch_q <= 1'b0; // RQ12
      end
    end
  end

  // Data toggles, untouched by soft reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_toggle_q <= 1'b0;
      wdata_toggle_q <= 1'b0;
    end else begin
      if (rdata_fall) begin
        rdata_toggle_q <= !rdata_toggle_q; // RQ8
      end
      if (wdata_fall) begin
        wdata_toggle_q <= !wdata_toggle_q; // RQ8
      end
    end
  end

  // Status A, enhanced layout
  assign status_a_enh = {
    irq_level_q, // RQ5
    drive_in.second_unit_present_n,
    drive_in.step_out,
    !drive_in.track_zero,
    drive_in.head_side_select,
    !drive_in.index_pulse,
    drive_in.write_protect_n,
    drive_in.head_inward
  }; // RQ2

  // Status A, alternate layout
  assign status_a_alt = {
    irq_level_q, // RQ5
    drq_out_q && drq_oe_q,
    step_latch_q,
    drive_in.track_zero,
    !drive_in.head_side_select,
    drive_in.index_pulse,
    !drive_in.write_protect_n,
    !drive_in.head_inward
  }; // RQ3

  // Status B, enhanced layout
  assign status_b_enh = {
    fhsc_pkg::STB_ENH_FIXED, // RQ6
    doc_q[fhsc_pkg::DOC_SEL_LO], // RQ9
    wdata_toggle_q,
    rdata_toggle_q,
    drive_in.write_gate, // RQ6
    motor_on_q[1:0] // RQ7
  };

  // Status B, alternate layout
  assign status_b_alt = {
    drive_in.second_unit_present_n,
    !unit_select_q[1],
    !unit_select_q[0],
    wdata_latch_q,
    rdata_latch_q,
    wr_gate_latch_q,
    !unit_select_q[3],
    !unit_select_q[2]
  }; // RQ10

  // Read decode; unlisted and reserved offsets leave the bus undriven
  always_comb begin
    rd_val = 8'h00;
    rd_oe = fhsc_pkg::OE_NONE;
    case (io_addr)
      fhsc_pkg::OFS_STATUS_A: begin
        case (host_mode)
          fhsc_pkg::MODE_ENHANCED: begin
            rd_val = status_a_enh; // RQ1
            rd_oe = fhsc_pkg::OE_ALL;
          end
          fhsc_pkg::MODE_ALTERNATE: begin
            rd_val = status_a_alt;
            rd_oe = fhsc_pkg::OE_ALL;
          end
          default: begin
            rd_oe = fhsc_pkg::OE_NONE; // RQ1
          end
        endcase
      end
      fhsc_pkg::OFS_STATUS_B: begin
        case (host_mode)
          fhsc_pkg::MODE_ENHANCED: begin
            rd_val = status_b_enh; // RQ1
            rd_oe = fhsc_pkg::OE_ALL;
          end
          fhsc_pkg::MODE_ALTERNATE: begin
            rd_val = status_b_alt;
            rd_oe = fhsc_pkg::OE_ALL;
          end
          default: begin
            rd_oe = fhsc_pkg::OE_NONE; // RQ1
          end
        endcase
      end
      fhsc_pkg::OFS_DRIVE_OUT: begin
        rd_val = doc_q; // RQ22
        rd_oe = fhsc_pkg::OE_ALL;
      end
      fhsc_pkg::OFS_TAPE_SEL: begin
        rd_val = {6'h00, tape_q}; // RQ22
        // Basic mode floats the upper six bits
        rd_oe = (host_mode == fhsc_pkg::MODE_BASIC) ? fhsc_pkg::OE_TAPE_BASIC
                                                      : fhsc_pkg::OE_ALL;
      end
      fhsc_pkg::OFS_MAIN_RATE, fhsc_pkg::OFS_DATA_PORT, fhsc_pkg::OFS_INPUT_CFG: begin
        rd_val = ext_rd_data; // RQ21
        rd_oe = fhsc_pkg::OE_ALL;
      end
      fhsc_pkg::OFS_RESERVED: begin
        rd_oe = fhsc_pkg::OE_NONE; // RQ21
      end
      default: begin
        rd_oe = fhsc_pkg::OE_NONE;
      end
    endcase
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
      io_rdata_oe_q <= fhsc_pkg::OE_NONE;
    end else if (io_rd) begin
      io_rdata_q <= rd_val;
      io_rdata_oe_q <= rd_oe;
    end else begin
      io_rdata_oe_q <= fhsc_pkg::OE_NONE;
    end
  end

  // Strobes toward registers kept elsewhere
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_rd_q <= 1'b0;
      ext_wr_q <= 1'b0;
      ext_addr_q <= 3'h0;
      ext_wdata_q <= 8'h00;
    end else begin
      ext_rd_q <= io_rd && ((io_addr == fhsc_pkg::OFS_MAIN_RATE) ||
                  (io_addr == fhsc_pkg::OFS_DATA_PORT) ||
                  (io_addr == fhsc_pkg::OFS_INPUT_CFG)); // RQ21
      ext_wr_q <= io_wr && ((io_addr == fhsc_pkg::OFS_MAIN_RATE) ||
                  (io_addr == fhsc_pkg::OFS_DATA_PORT) ||
                  (io_addr == fhsc_pkg::OFS_INPUT_CFG)); // RQ21
      if (io_rd || io_wr) begin
        ext_addr_q <= io_addr;
        ext_wdata_q <= io_wdata;
      end
    end
  end

endmodule

`default_nettype wire

// file: hw/fhsc_pkg.sv
package fhsc_pkg;

  // Register offsets from the block base
  localparam logic [2:0] OFS_STATUS_A = 3'h0;
  localparam logic [2:0] OFS_STATUS_B = 3'h1;
  localparam logic [2:0] OFS_DRIVE_OUT = 3'h2;
  localparam logic [2:0] OFS_TAPE_SEL = 3'h3;
  localparam logic [2:0] OFS_MAIN_RATE = 3'h4;
  localparam logic [2:0] OFS_DATA_PORT = 3'h5;
  localparam logic [2:0] OFS_RESERVED = 3'h6;
  localparam logic [2:0] OFS_INPUT_CFG = 3'h7;

  // Field positions in drive_output_control
  localparam int DOC_SEL_LO = 0;
  localparam int DOC_SEL_HI = 1;
  localparam int DOC_RESET_N = 2;
  localparam int DOC_DMA_EN = 3;
  localparam int DOC_MOTOR_LO = 4;
  localparam int DOC_MOTOR_HI = 7;

  // Reset values
  localparam logic [7:0] DOC_RESET = 8'h00;
  localparam logic [1:0] TAPE_RESET = 2'h0;
  localparam logic [3:0] SEL_RESET = 4'h1;

  // Read-back constants
  localparam logic [1:0] STB_ENH_FIXED = 2'h3;
  localparam logic [7:0] OE_ALL = 8'hff;
  localparam logic [7:0] OE_NONE = 8'h00;
  localparam logic [7:0] OE_TAPE_BASIC = 8'h03;

  // Software reset stretch
  localparam int CLK_PERIOD_NS = 10;
  localparam int SRST_MIN_NS = 100;
  localparam int SRST_MIN_CYC = (SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    MODE_BASIC = 2'b00,
    MODE_ENHANCED = 2'b01,
    MODE_ALTERNATE = 2'b10
  } fhsc_mode_t;

  // Drive interface levels, all active high unless suffixed _n
  typedef struct packed {
    logic head_inward;
    logic write_protect_n;
    logic index_pulse;
    logic head_side_select;
    logic track_zero;
    logic step_out;
    logic second_unit_present_n;
    logic write_gate;
    logic read_data;
    logic write_data;
  } fhsc_drive_t;

  // Core-side DMA and interrupt signals
  typedef struct packed {
    logic drq;
    logic irq;
    logic dack_n;
    logic tc;
  } fhsc_dma_t;

endpackage

// file: verif/fhsc_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module fhsc_drive_model (
  // Levels asked for by the bench
  input wire fhsc_pkg::fhsc_drive_t lvl,
  input wire logic [3:0] motor_on,
  // Pins seen by the block
  output var fhsc_pkg::fhsc_drive_t drive
);
  // A stopped spindle gives no index
  always_comb begin
    drive = lvl;
    drive.index_pulse = lvl.index_pulse && (motor_on != 4'h0);
  end
endmodule
`default_nettype wire

// file: verif/fhsc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fhsc_regs_chk (
  // Clock, reset, mode
  input wire logic clk_sys,
  input wire logic rst,
  input wire fhsc_pkg::fhsc_mode_t host_mode,
  // Host bus
  input wire logic [2:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_rdata_q,
  input wire logic [7:0] io_rdata_oe_q,
  input wire logic ext_rd_q,
  input wire logic ext_wr_q,
  input wire logic [2:0] ext_addr_q,
  input wire logic [7:0] ext_wdata_q,
  // Drive and gating
  input wire logic [3:0] unit_select_q,
  input wire logic [3:0] motor_on_q,
  input wire logic soft_reset_n_q,
  input wire logic dma_gate_enable_q,
  input wire logic drq_oe_q,
  input wire logic controller_irq_oe_q,
  input wire logic dack_n_gated_q,
  input wire logic tc_gated_q
);
  logic enh;
  assign enh = host_mode == fhsc_pkg::MODE_ENHANCED;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  oe_cause_a: assert property (io_rdata_oe_q != 8'h00 |-> $past(io_rd))
    else $error("bus driven without a read");
  basic_float_a: assert property (io_rd && io_addr < 3'h2
    && host_mode != fhsc_pkg::MODE_ENHANCED && host_mode != fhsc_pkg::MODE_ALTERNATE
    |=> io_rdata_oe_q == 8'h00) else $error("status driven in basic mode");
  enh_stb_a: assert property (io_rd && io_addr == 3'h1 && enh |=> io_rdata_oe_q == 8'hff
    && io_rdata_q[7:6] == 2'h3 && io_rdata_q[1:0] == $past(motor_on_q[1:0]))
    else $error("enhanced status b wrong");
  sel_onehot_a: assert property ($onehot(unit_select_q))
    else $error("unit select not one-hot");
  motor_wr_a: assert property (io_wr && io_addr == 3'h2
    |-> ##2 motor_on_q == $past(io_wdata[7:4], 2)) else $error("motor outputs wrong");
  srst_hold_a: assert property (io_wr && io_addr == 3'h2 && !io_wdata[2]
    |-> ##2 !soft_reset_n_q [*8]) else $error("soft reset too short");
  enh_gate_a: assert property (enh |=> drq_oe_q && controller_irq_oe_q)
    else $error("pins floated in enhanced mode");
  dma_off_a: assert property (!enh && !dma_gate_enable_q && $past(!dma_gate_enable_q)
    |-> !drq_oe_q && !controller_irq_oe_q && dack_n_gated_q && !tc_gated_q)
    else $error("gating open");
  ext_rd_a: assert property (io_rd && io_addr == 3'h7 |=> ext_rd_q
    && ext_addr_q == 3'h7) else $error("input status strobe");
  ext_wr_a: assert property (io_wr && io_addr == 3'h5 |=> ext_wr_q
    && ext_addr_q == 3'h5 && ext_wdata_q == $past(io_wdata)) else $error("data port strobe");
  ctl_local_a: assert property (io_wr && io_addr == 3'h2 |=> !ext_wr_q)
    else $error("control write leaked");
  cover property (io_rd && io_addr == 3'h1 && enh);
  cover property (io_wr && io_addr == 3'h2 && !io_wdata[2]);
  cover property (io_rd && io_addr == 3'h7);
endmodule
bind fhsc_regs fhsc_regs_chk fhsc_regs_chk_inst (.clk_sys, .rst, .host_mode, .io_addr,
  .io_wdata, .io_rd, .io_wr, .io_rdata_q, .io_rdata_oe_q, .ext_rd_q, .ext_wr_q, .ext_addr_q,
  .ext_wdata_q, .unit_select_q, .motor_on_q, .soft_reset_n_q, .dma_gate_enable_q,
  .drq_oe_q, .controller_irq_oe_q, .dack_n_gated_q, .tc_gated_q);
`default_nettype wire

// file: verif/fhsc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fhsc_regs_bench;
  logic clk_sys, rst, io_rd, io_wr, ext_rd_q, ext_wr_q, soft_reset_n_q, dma_gate_enable_q;
  logic drq_out_q, drq_oe_q, controller_irq_out_q, controller_irq_oe_q;
  logic dack_n_gated_q, tc_gated_q;
  fhsc_pkg::fhsc_mode_t host_mode;
  logic [2:0] io_addr, ext_addr_q;
  logic [7:0] io_wdata, io_rdata_q, io_rdata_oe_q, ext_rd_data, ext_wdata_q, d, oe;
  logic [3:0] unit_select_q, motor_on_q;
  fhsc_pkg::fhsc_drive_t lvl, drive_in;
  fhsc_pkg::fhsc_dma_t core_in;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  // Rows: control value, expected selects, expected motors
  logic [15:0] rows [5] = '{16'h1c11, 16'h2d22, 16'h4e44, 16'h8f88, 16'hf38f};
  logic [2:0] quiet [3] = '{3'h0, 3'h1, 3'h6};
  fhsc_drive_model fhsc_drive_model_inst (.lvl(lvl), .motor_on(motor_on_q), .drive(drive_in));
  fhsc_regs fhsc_regs_inst (.clk_sys, .rst, .host_mode, .io_addr, .io_wdata, .io_rd,
    .io_wr, .io_rdata_q, .io_rdata_oe_q, .ext_rd_data, .ext_rd_q, .ext_wr_q, .ext_addr_q,
    .ext_wdata_q, .drive_in, .unit_select_q, .motor_on_q, .core_in, .soft_reset_n_q,
    .dma_gate_enable_q, .drq_out_q, .drq_oe_q, .controller_irq_out_q,
    .controller_irq_oe_q, .dack_n_gated_q, .tc_gated_q);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Every access ends with an idle cycle so strobes never retoggle in one step
  task automatic rd(input logic [2:0] a);
    io_rd = 1'b1;
    io_addr = a;
    @(negedge clk_sys);
    io_rd = 1'b0;
    d = io_rdata_q;
    oe = io_rdata_oe_q;
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = v;
    @(negedge clk_sys);
    io_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic reboot(input fhsc_pkg::fhsc_mode_t m, input int c);
    rst = 1'b1;
    host_mode = m;
    repeat (c) @(negedge clk_sys);
    rst = 1'b0;
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = 3'h0;
    io_wdata = 8'h00;
    ext_rd_data = 8'h00;
    lvl = '{head_inward: 1'b1, write_protect_n: 1'b1, head_side_select: 1'b1, default: 1'b0};
    core_in = '{dack_n: 1'b1, default: 1'b0};
    reboot(fhsc_pkg::MODE_ENHANCED, 20);
    chk("enh pins in reset", {6'h0, drq_oe_q, controller_irq_oe_q}, 8'h03);
    rd(3'h2);
    chk("control reset", d, 8'h00);
    rd(3'h0);
    chk("enh status a", d, 8'h1f);
    for (int i = 0; i < 5; i++) begin
      wr(3'h2, rows[i][15:8]);
      chk("unit select", {4'h0, unit_select_q}, {4'h0, rows[i][7:4]});
      chk("motor", {4'h0, motor_on_q}, {4'h0, rows[i][3:0]});
      chk("dma enable", {7'h0, dma_gate_enable_q}, {7'h0, rows[i][11]});
      rd(3'h2);
      chk("control", d, rows[i][15:8]);
      rd(3'h1);
      chk("enh status b", d, {2'h3, rows[i][8], 3'h0, rows[i][13:12]});
    end
    wr(3'h2, 8'h1c);
    lvl.read_data = 1'b1;
    @(negedge clk_sys);
    lvl.read_data = 1'b0;
    lvl.write_data = 1'b1;
    @(negedge clk_sys);
    lvl.write_data = 1'b0;
    @(negedge clk_sys);
    rd(3'h1);
    chk("data toggles", d, 8'hd9);
    // Clear then set the reset bit on adjacent cycles
    io_wr = 1'b1;
    io_addr = 3'h2;
    io_wdata = 8'h18;
    @(negedge clk_sys);
    io_wdata = 8'h1c;
    @(negedge clk_sys);
    io_wr = 1'b0;
    @(negedge clk_sys);
    chk("soft reset low", {7'h0, soft_reset_n_q}, 8'h00);
    n = 0;
    while (soft_reset_n_q !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("soft reset length", 8'(n >= 6 && n < 40), 8'h01);
    rd(3'h2);
    chk("control kept", d, 8'h1c);
    rd(3'h1);
    chk("status b kept", d, 8'hd9);
    lvl.head_inward = 1'b0;
    lvl.head_side_select = 1'b0;
    core_in.drq = 1'b1;
    reboot(fhsc_pkg::MODE_ALTERNATE, 2);
    rd(3'h0);
    chk("alt status a reset", d, 8'h09);
    wr(3'h2, 8'h0c);
    core_in.irq = 1'b1;
    lvl.step_out = 1'b1;
    lvl.write_gate = 1'b1;
    lvl.write_data = 1'b1;
    @(negedge clk_sys);
    lvl.step_out = 1'b0;
    lvl.write_gate = 1'b0;
    lvl.write_data = 1'b0;
    @(negedge clk_sys);
    chk("drq enabled", {7'h0, drq_oe_q}, 8'h01);
    rd(3'h0);
    chk("alt status a", d, 8'he9);
    rd(3'h1);
    chk("alt status b", d, 8'h57);
    ext_rd_data = 8'ha5;
    rd(3'h7);
    chk("input status", d, 8'ha5);
    rd(3'h1);
    chk("alt latches clear", d, 8'h43);
    rd(3'h0);
    chk("step clear", d, 8'hc9);
    core_in.dack_n = 1'b0;
    core_in.tc = 1'b1;
    reboot(fhsc_pkg::MODE_BASIC, 2);
    foreach (quiet[i]) begin
      rd(quiet[i]);
      chk("basic float", oe, 8'h00);
    end
    chk("basic drq off", {7'h0, drq_oe_q}, 8'h00);
    chk("basic gated", {5'h0, controller_irq_oe_q, dack_n_gated_q, tc_gated_q}, 8'h02);
    wr(3'h3, 8'hff);
    rd(3'h3);
    chk("tape enable", oe, 8'h03);
    chk("tape data", {6'h0, d[1:0]}, 8'h03);
    wr(3'h5, 8'h5a);
    chk("port addr", {5'h0, ext_addr_q}, 8'h05);
    chk("port data", ext_wdata_q, 8'h5a);
    wr(3'h2, 8'h0c);
    @(negedge clk_sys);
    chk("basic drq on", {7'h0, drq_oe_q}, 8'h01);
    chk("basic pins on", {4'h0, controller_irq_out_q, controller_irq_oe_q, dack_n_gated_q,
      tc_gated_q}, 8'h0d);
    give_verdict();
  end
endmodule
`default_nettype wire
